// File: inc/led_cfg_pkg.sv
// constants and carrier types for the led drive and slot a register bank
package led_cfg_pkg;

    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 16;

    // register offsets on the host register port
    localparam logic [7:0]  OFS_LED_ONE    = 8'h23;
    localparam logic [7:0]  OFS_LED_TWO    = 8'h24;
    localparam logic [7:0]  OFS_FINE_TRIM  = 8'h25;
    localparam logic [7:0]  OFS_SLOT_SHAPE = 8'h30;
    localparam logic [7:0]  OFS_SLOT_COUNT = 8'h31;
    localparam logic [7:0]  OFS_EMITTER    = 8'h3f;

    // field positions (low bit of each field)
    localparam int          POS_EDGE_RATE  = 4;
    localparam int          POS_STEP       = 0;
    localparam int          POS_STRENGTH   = 13;
    localparam int          POS_TRIM_ONE   = 0;
    localparam int          POS_TRIM_TWO   = 6;
    localparam int          POS_TRIM_THREE = 11;
    localparam int          POS_PULSE_LEN  = 8;
    localparam int          POS_PULSE_DLY  = 0;
    localparam int          POS_PULSE_CNT  = 8;
    localparam int          POS_PULSE_PER  = 0;

    // reset values of whole registers, and of each five-bit trim field
    localparam logic [15:0] RST_LED_ONE    = 16'h3000;
    localparam logic [15:0] RST_LED_TWO    = 16'h3000;
    localparam logic [15:0] RST_FINE_TRIM  = 16'h630c;
    localparam logic [15:0] RST_SLOT_SHAPE = 16'h0320;
    localparam logic [15:0] RST_SLOT_COUNT = 16'h0818;
    localparam logic [1:0]  RST_EMITTER    = 2'h1;
    localparam logic [4:0]  RST_TRIM       = 5'h0c;

    // emitter choice codes
    localparam logic [1:0]  EMIT_NONE      = 2'h0;
    localparam logic [1:0]  EMIT_ONE       = 2'h1;
    localparam logic [1:0]  EMIT_TWO       = 2'h2;
    localparam logic [1:0]  EMIT_THREE     = 2'h3;

    // microsecond unit derived from the 10 MHz reference
    localparam int          TICK_UNIT_NS   = 1000;
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          US_CYCLES      = TICK_UNIT_NS / CLK_PERIOD_NS;
    localparam int          TICK_W         = 16;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [7:0]        addr;
        logic [15:0]       wdata;
    } reg_req_type;

    typedef struct packed {
        logic [2:0]        edge_rate;
        logic [3:0]        current_step;
        logic              strength_select;
        logic [4:0]        trim;
    } led_channel_type;

    typedef struct packed {
        logic [1:0]        emitter_choice;
        logic [4:0]        pulse_length;
        logic [7:0]        pulse_delay;
        logic [7:0]        pulse_count;
        logic [7:0]        pulse_period;
    } slot_a_type;

endpackage

// File: logic/led_slot_a_config.sv
// register bank for led drive strength and slot a pulse timing
//
// Contract
// - three-bit edge rate, bits 6:4, 0 slowest
// - four-bit current step, bits 3:0, resets 0x0
// - peak current is coarse times fine times scale
// - shared trim register, three five-bit fine codes
// - led two bit 13 selects full strength
// - trims reset to 0xc, bit 5 reserved
// - pulse length bits 12:8, microseconds, reset 0x3
// - pulse delay bits 7:0, microseconds, reset 0x20
// - emitter choice two bits, reset 0x1
// - led one bit 13 selects full strength
// - pulse count bits 15:8, reset 0x08
`timescale 1ns/100ps
module led_slot_a_config #(
    parameter int US_CYCLES_P = led_cfg_pkg::US_CYCLES
) (
    input  wire logic                        REF_CLK,
    input  wire logic                        RST_B,
    input  wire led_cfg_pkg::reg_req_type    REG_REQ,
    output logic [15:0]                      REG_RDATA,
    output led_cfg_pkg::led_channel_type     LED_ONE,
    output led_cfg_pkg::led_channel_type     LED_TWO,
    output logic [4:0]                       LED_THREE_TRIM,
    output led_cfg_pkg::slot_a_type          SLOT_A,
    output logic                             US_TICK
);
    import led_cfg_pkg::*;

    logic [15:0]       led_one_q;
    logic [15:0]       led_one_d;
    logic [15:0]       led_two_q;
    logic [15:0]       led_two_d;
    logic [15:0]       fine_q;
    logic [15:0]       fine_d;
    logic [15:0]       shape_q;
    logic [15:0]       shape_d;
    logic [15:0]       count_q;
    logic [15:0]       count_d;
    logic [1:0]        emitter_q;
    logic [1:0]        emitter_d;
    logic [15:0]       rdata_q;
    logic [15:0]       rdata_d;
    logic [TICK_W-1:0] tick_cnt_q;
    logic [TICK_W-1:0] tick_cnt_d;
    logic              tick_q;
    logic              tick_d;

    wire               sel_led_one;
    wire               sel_led_two;
    wire               sel_fine;
    wire               sel_shape;
    wire               sel_count;
    wire               sel_emitter;
    wire               wr_led_one;
    wire               wr_led_two;
    wire               wr_fine;
    wire               wr_shape;
    wire               wr_count;
    wire               wr_emitter;
    wire [15:0]        read_mux;
    wire               tick_wrap;

    // address decode
    assign sel_led_one = (REG_REQ.addr == OFS_LED_ONE);
    assign sel_led_two = (REG_REQ.addr == OFS_LED_TWO);
    assign sel_fine    = (REG_REQ.addr == OFS_FINE_TRIM);
    assign sel_shape   = (REG_REQ.addr == OFS_SLOT_SHAPE);
    assign sel_count   = (REG_REQ.addr == OFS_SLOT_COUNT);
    assign sel_emitter = (REG_REQ.addr == OFS_EMITTER);

    assign wr_led_one  = REG_REQ.wr && sel_led_one;
    assign wr_led_two  = REG_REQ.wr && sel_led_two;
    assign wr_fine     = REG_REQ.wr && sel_fine;
    assign wr_shape    = REG_REQ.wr && sel_shape;
    assign wr_count    = REG_REQ.wr && sel_count;
    assign wr_emitter  = REG_REQ.wr && sel_emitter;

    // reserved bits of the 16-bit registers are stored as written so software sees its own values
    assign led_one_d = wr_led_one ? REG_REQ.wdata : led_one_q;
    assign led_two_d = wr_led_two ? REG_REQ.wdata : led_two_q;
    assign fine_d    = wr_fine    ? REG_REQ.wdata : fine_q;
    assign shape_d   = wr_shape   ? REG_REQ.wdata : shape_q;
    assign count_d   = wr_count   ? REG_REQ.wdata : count_q;
    assign emitter_d = wr_emitter ? REG_REQ.wdata[1:0] : emitter_q;

    // unmapped offsets read as zero; upper emitter bits read as zero
    assign read_mux =
        sel_led_one ? led_one_q :
        sel_led_two ? led_two_q :
        sel_fine    ? fine_q    :
        sel_shape   ? shape_q   :
        sel_count   ? count_q   :
        sel_emitter ? {14'h0000, emitter_q} :
        16'h0000;
    assign rdata_d = REG_REQ.rd ? read_mux : rdata_q;

    // tick counter never pauses, so every unit edge is a whole microsecond
    assign tick_wrap  = (tick_cnt_q == TICK_W'(US_CYCLES_P - 1));
    assign tick_cnt_d = tick_wrap ? '0 : tick_cnt_q + TICK_W'(1);
    assign tick_d     = tick_wrap;

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            led_one_q <= RST_LED_ONE;
            led_two_q <= RST_LED_TWO;
            fine_q    <= RST_FINE_TRIM;
            shape_q   <= RST_SLOT_SHAPE;
            count_q   <= RST_SLOT_COUNT;
            emitter_q <= RST_EMITTER;
        end else begin
            led_one_q <= led_one_d;
            led_two_q <= led_two_d;
            fine_q    <= fine_d;
            shape_q   <= shape_d;
            count_q   <= count_d;
            emitter_q <= emitter_d;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            rdata_q    <= 16'h0000;
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            rdata_q    <= rdata_d;
            tick_cnt_q <= tick_cnt_d;
            tick_q     <= tick_d;
        end
    end

    // field extraction straight from register bits; the coarse, fine and
    // scale codes go out raw, the analog side forms the product
    assign LED_ONE.edge_rate       = led_one_q[POS_EDGE_RATE +: 3];
    assign LED_ONE.current_step    = led_one_q[POS_STEP +: 4];
    assign LED_ONE.strength_select = led_one_q[POS_STRENGTH];
    assign LED_ONE.trim            = fine_q[POS_TRIM_ONE +: 5];
    assign LED_TWO.edge_rate       = led_two_q[POS_EDGE_RATE +: 3];
    assign LED_TWO.current_step    = led_two_q[POS_STEP +: 4];
    // low strength level of led two is analog; the bit only selects it
    assign LED_TWO.strength_select = led_two_q[POS_STRENGTH];
    assign LED_TWO.trim            = fine_q[POS_TRIM_TWO +: 5];
    assign LED_THREE_TRIM          = fine_q[POS_TRIM_THREE +: 5];
    assign SLOT_A.emitter_choice   = emitter_q;
    assign SLOT_A.pulse_length     = shape_q[POS_PULSE_LEN +: 5];
    assign SLOT_A.pulse_delay      = shape_q[POS_PULSE_DLY +: 8];
    assign SLOT_A.pulse_count      = count_q[POS_PULSE_CNT +: 8];
    assign SLOT_A.pulse_period     = count_q[POS_PULSE_PER +: 8];
    assign REG_RDATA               = rdata_q;
    assign US_TICK                 = tick_q;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);

    AST_EDGE_RATE_WRITE: assert property (
        wr_led_two |=> LED_TWO.edge_rate == $past(REG_REQ.wdata[6:4])
    ) else $error("led two edge rate not taken from bits 6:4");

    AST_STEP_RESET: assert property (
        $rose(RST_B) |-> LED_ONE.current_step == 4'h0
            && LED_TWO.current_step == 4'h0
    ) else $error("current step not zero after reset");

    AST_STEP_HOLD: assert property (
        !wr_led_one |=> $stable(LED_ONE.current_step)
    ) else $error("led one current step changed without a write");

    AST_TRIM_THREE_WRITE: assert property (
        wr_fine |=> LED_THREE_TRIM == $past(REG_REQ.wdata[15:11])
            && LED_ONE.trim == $past(REG_REQ.wdata[4:0])
    ) else $error("trim fields not taken from shared register");

    AST_STRENGTH_RESET: assert property (
        $rose(RST_B) |-> LED_TWO.strength_select && LED_ONE.strength_select
    ) else $error("strength select not full after reset");

    AST_TRIM_RESET: assert property (
        $rose(RST_B) |-> LED_ONE.trim == RST_TRIM
            && LED_TWO.trim == RST_TRIM && LED_THREE_TRIM == RST_TRIM
    ) else $error("trim codes not 0xc after reset");

    AST_SHAPE_RESET: assert property (
        $rose(RST_B) |-> SLOT_A.pulse_length == 5'h03
            && SLOT_A.pulse_delay == 8'h20
    ) else $error("pulse length or delay reset value wrong");

    AST_DELAY_WRITE: assert property (
        wr_shape ##1 !wr_shape |-> SLOT_A.pulse_delay
            == $past(REG_REQ.wdata[7:0])
    ) else $error("pulse delay not taken from bits 7:0");

    AST_EMITTER_RESET: assert property (
        $rose(RST_B) |-> SLOT_A.emitter_choice == EMIT_ONE
    ) else $error("emitter choice not one after reset");

    AST_STRENGTH_WRITE: assert property (
        wr_led_one |=> LED_ONE.strength_select == $past(REG_REQ.wdata[13])
    ) else $error("led one strength not taken from bit 13");

    AST_COUNT_RESET: assert property (
        $rose(RST_B) |-> SLOT_A.pulse_count == 8'h08
    ) else $error("pulse count reset value wrong");

    AST_READ_BACK: assert property (
        wr_led_two ##1 (REG_REQ.rd && sel_led_two && !REG_REQ.wr)
            |=> REG_RDATA == $past(REG_REQ.wdata, 2)
    ) else $error("led two register read back differs from write");

    AST_UNMAPPED_ZERO: assert property (
        REG_REQ.rd && !(sel_led_one || sel_led_two || sel_fine
            || sel_shape || sel_count || sel_emitter) |=> REG_RDATA == 16'h0
    ) else $error("unmapped read not zero");

    AST_TICK_SPACING: assert property (
        US_TICK |=> !US_TICK [*8] ##1 !US_TICK ##1 US_TICK
    ) else $error("microsecond tick spacing wrong");

    AST_EDGE_RATE_ONE: assert property (
        wr_led_one |=> LED_ONE.edge_rate == $past(REG_REQ.wdata[6:4])
    ) else $error("led one edge rate not taken from bits 6:4");

    AST_STEP_ONE_WRITE: assert property (
        wr_led_one |=> LED_ONE.current_step == $past(REG_REQ.wdata[3:0])
    ) else $error("led one current step not taken from bits 3:0");

    AST_STEP_TWO_WRITE: assert property (
        wr_led_two |=> LED_TWO.current_step == $past(REG_REQ.wdata[3:0])
    ) else $error("led two current step not taken from bits 3:0");

    AST_TRIM_TWO_WRITE: assert property (
        wr_fine |=> LED_TWO.trim == $past(REG_REQ.wdata[10:6])
    ) else $error("led two trim not taken from bits 10:6");

    AST_TRIM_HOLD: assert property (
        !wr_fine |=> $stable(LED_THREE_TRIM) && $stable(LED_ONE.trim)
            && $stable(LED_TWO.trim)
    ) else $error("trim codes changed without a write");

    AST_STRENGTH_TWO_WRITE: assert property (
        wr_led_two |=> LED_TWO.strength_select == $past(REG_REQ.wdata[13])
    ) else $error("led two strength not taken from bit 13");

    // reserved bit between the trims is kept as written, not forced
    AST_TRIM_SPARE_KEPT: assert property (
        wr_fine |=> fine_q[5] == $past(REG_REQ.wdata[5])
    ) else $error("reserved trim bit not stored as written");

    AST_LENGTH_WRITE: assert property (
        wr_shape |=> SLOT_A.pulse_length == $past(REG_REQ.wdata[12:8])
    ) else $error("pulse length not taken from bits 12:8");

    AST_SHAPE_HOLD: assert property (
        !wr_shape |=> $stable(SLOT_A.pulse_length)
            && $stable(SLOT_A.pulse_delay)
    ) else $error("pulse length or delay changed without a write");

    AST_EMITTER_WRITE: assert property (
        wr_emitter |=> SLOT_A.emitter_choice == $past(REG_REQ.wdata[1:0])
    ) else $error("emitter choice not taken from bits 1:0");

    AST_EMITTER_HOLD: assert property (
        !wr_emitter |=> $stable(SLOT_A.emitter_choice)
    ) else $error("emitter choice changed without a write");

    AST_LED_ONE_HOLD: assert property (
        !wr_led_one |=> $stable(LED_ONE.strength_select)
            && $stable(LED_ONE.edge_rate)
    ) else $error("led one strength or edge rate changed without a write");

    AST_COUNT_WRITE: assert property (
        wr_count |=> SLOT_A.pulse_count == $past(REG_REQ.wdata[15:8])
            && SLOT_A.pulse_period == $past(REG_REQ.wdata[7:0])
    ) else $error("pulse count or period not taken from register");

    AST_COUNT_HOLD: assert property (
        !wr_count |=> $stable(SLOT_A.pulse_count)
            && $stable(SLOT_A.pulse_period)
    ) else $error("pulse count or period changed without a write");

    // a read answers with the value held before any write of that edge
    AST_READ_LED_ONE: assert property (
        REG_REQ.rd && sel_led_one |=> REG_RDATA[13]
            == $past(LED_ONE.strength_select) && REG_RDATA[6:0]
            == $past({LED_ONE.edge_rate, LED_ONE.current_step})
    ) else $error("led one read back differs from its fields");

    AST_READ_SHAPE: assert property (
        REG_REQ.rd && sel_shape |=> REG_RDATA[12:0]
            == $past({SLOT_A.pulse_length, SLOT_A.pulse_delay})
    ) else $error("slot a shape read back differs from its fields");

    AST_READ_EMITTER: assert property (
        REG_REQ.rd && sel_emitter |=> REG_RDATA[15:2] == 14'h0000
            && REG_RDATA[1:0] == $past(SLOT_A.emitter_choice)
    ) else $error("emitter choice read back wrong");

    AST_READ_HOLD: assert property (
        !REG_REQ.rd |=> $stable(REG_RDATA)
    ) else $error("read data changed without a read");

    AST_TICK_SINGLE: assert property (
        US_TICK |=> !US_TICK
    ) else $error("microsecond tick longer than one cycle");

    AST_TICK_RESET: assert property (
        $rose(RST_B) |-> !US_TICK
    ) else $error("microsecond tick high straight after reset");

    COV_WRITE_SHAPE: cover property (wr_shape ##1 REG_REQ.rd && sel_shape);
    COV_WRITE_READ_SAME: cover property (
        REG_REQ.wr && REG_REQ.rd && sel_led_two);
    COV_EMITTER_NONE: cover property (SLOT_A.emitter_choice == EMIT_NONE);
    COV_LOW_STRENGTH: cover property (!LED_TWO.strength_select);
    COV_TICK_PAIR: cover property (US_TICK ##10 US_TICK);

endmodule

// File: testbench/tb_led_slot_a_config.sv
// self-checking bench for the led drive and slot a register bank
`timescale 1ns/100ps
module tb_led_slot_a_config;
    import led_cfg_pkg::*;

    logic            clk = 1'b0;
    logic            rst_b;
    reg_req_type     req;
    logic [15:0]     rdata;
    led_channel_type led_one;
    led_channel_type led_two;
    logic [4:0]      led_three_trim;
    slot_a_type      slot_a;
    logic            us_tick;
    int              n_fail;
    int              n_tests;

    led_slot_a_config #(.US_CYCLES_P(10)) dut_u (
        .REF_CLK        (clk),
        .RST_B          (rst_b),
        .REG_REQ        (req),
        .REG_RDATA      (rdata),
        .LED_ONE        (led_one),
        .LED_TWO        (led_two),
        .LED_THREE_TRIM (led_three_trim),
        .SLOT_A         (slot_a),
        .US_TICK        (us_tick)
    );

    always #50 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one request held across exactly one edge, then released
    task automatic op(input logic w, input logic r, input logic [7:0] a,
                      input logic [15:0] d);
        @(posedge clk);
        #1;
        req = reg_req_type'{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        op(1'b0, 1'b1, a, 16'h0000);
        check(32'(rdata), 32'(exp));
    endtask

    task automatic test_reset;
        check(32'(led_one), 32'({3'h0, 4'h0, 1'b1, 5'h0c}));
        check(32'(led_two), 32'({3'h0, 4'h0, 1'b1, 5'h0c}));
        check(32'(led_three_trim), 32'h0c);
        check(32'(slot_a), 32'({2'h1, 5'h03, 8'h20, 8'h08, 8'h18}));
        rd(8'h23, 16'h3000);
        rd(8'h24, 16'h3000);
        rd(8'h25, 16'h630c);
        rd(8'h30, 16'h0320);
        rd(8'h31, 16'h0818);
        $display("test reset done");
    endtask

    // reserved bit 12 written as one, other reserved bits zero
    task automatic test_fields;
        op(1'b1, 1'b0, 8'h23, 16'h105f);
        check(32'(led_one[12:5]), 32'({3'h5, 4'hf, 1'b0}));
        op(1'b1, 1'b0, 8'h24, 16'h3073);
        check(32'(led_two[12:5]), 32'({3'h7, 4'h3, 1'b1}));
        op(1'b1, 1'b0, 8'h25, 16'hfbd1);
        check(32'(led_one.trim), 32'h11);
        check(32'(led_two.trim), 32'h0f);
        check(32'(led_three_trim), 32'h1f);
        op(1'b1, 1'b0, 8'h30, 16'h1fff);
        check(32'(slot_a.pulse_length), 32'h1f);
        check(32'(slot_a.pulse_delay), 32'hff);
        op(1'b1, 1'b0, 8'h31, 16'hff05);
        check(32'(slot_a.pulse_count), 32'hff);
        check(32'(slot_a.pulse_period), 32'h05);
        rd(8'h23, 16'h105f);
        rd(8'h24, 16'h3073);
        rd(8'h25, 16'hfbd1);
        rd(8'h30, 16'h1fff);
        rd(8'h31, 16'hff05);
        $display("test fields done");
    endtask

    // every emitter code, upper bits of the word must not stick
    task automatic test_emitter;
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 1'b0, OFS_EMITTER, 16'hfffc | 16'(i));
            check(32'(slot_a.emitter_choice), 32'(i));
            rd(OFS_EMITTER, 16'(i));
        end
        rd(8'h26, 16'h0000);
        $display("test emitter done");
    endtask

    // write then read on the next edge, then write and read together
    task automatic test_back_to_back;
        @(posedge clk);
        #1;
        req = reg_req_type'{wr: 1'b1, rd: 1'b0, addr: OFS_LED_TWO,
                            wdata: 16'h1025};
        @(posedge clk);
        #1;
        req = reg_req_type'{wr: 1'b0, rd: 1'b1, addr: OFS_LED_TWO,
                            wdata: 16'h0000};
        check(32'(led_two.strength_select), 32'h0);
        @(posedge clk);
        #1;
        check(32'(rdata), 32'h1025);
        req = reg_req_type'{wr: 1'b1, rd: 1'b1, addr: OFS_LED_TWO,
                            wdata: 16'h3000};
        @(posedge clk);
        #1;
        req = '0;
        check(32'(rdata), 32'h1025);
        check(32'(led_two.strength_select), 32'h1);
        $display("test back to back done");
    endtask

    // spacing between ticks sets the microsecond unit
    task automatic test_tick;
        int n;
        n = 0;
        while (us_tick !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(32'(us_tick), 32'h1);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (us_tick !== 1'b1 && n < 20);
        check(32'(n), 32'(US_CYCLES));
        $display("test tick done");
    endtask

    task automatic tally_and_finish;
        $display("tests=%0d failures=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #60000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        n_fail = 0;
        n_tests = 0;
        rst_b = 1'b0;
        req = '0;
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1'b1;
        test_reset();
        test_fields();
        test_emitter();
        test_back_to_back();
        test_tick();
        tally_and_finish();
    end
endmodule
